//--- common/afsp_pkg.sv
// constants, types and state layout for the serial channel
package afsp_pkg;
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_IIR_FCR = 3'h2;
  localparam logic [2:0] OFS_LCR = 3'h3;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  localparam int LCR_DIVISOR_WINDOW_SEL = 7;
  localparam int LCR_BRK = 6;
  localparam int LCR_STICK = 5;
  localparam int LCR_EVEN = 4;
  localparam int LCR_PEN = 3;
  localparam int LCR_STB = 2;
  localparam int FCR_EN = 0;
  localparam int FCR_RXF = 1;
  localparam int FCR_TXF = 2;
  localparam int FCR_DMA = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_USER_OUT_B = 3;
  localparam int MCR_USER_OUT_A = 2;
  localparam int MCR_RTS = 1;
  localparam int MCR_DTR = 0;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0e;
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LS = 4'h6;
  localparam logic [3:0] IIR_RDA = 4'h4;
  localparam logic [3:0] IIR_TO = 4'hc;
  localparam logic [3:0] IIR_TX_HOLD_VACANT = 4'h2;
  localparam logic [3:0] IIR_MS = 4'h0;
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] TICKS_STOP_1 = 6'h10;
  localparam logic [5:0] TICKS_STOP_15 = 6'h18;
  localparam logic [5:0] TICKS_STOP_2 = 6'h20;
  localparam logic [9:0] TIMEOUT_TICKS_PER_BIT = 10'h040;

  typedef enum logic [4:0] {
    AFSP_TX_IDLE = 5'b00001, AFSP_TX_START = 5'b00010, AFSP_TX_DATA = 5'b00100,
    AFSP_TX_PAR = 5'b01000, AFSP_TX_STOP = 5'b10000
  } afsp_tx_e;
  typedef enum logic [4:0] {
    AFSP_RX_IDLE = 5'b00001, AFSP_RX_START = 5'b00010, AFSP_RX_DATA = 5'b00100,
    AFSP_RX_PAR = 5'b01000, AFSP_RX_STOP = 5'b10000
  } afsp_rx_e;

  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } afsp_modem_in_s;
  typedef struct packed {
    logic user_out_b_n;
    logic user_out_a_n;
    logic rts_n;
    logic dtr_n;
  } afsp_modem_out_s;
  // queue entry: break, framing, parity, data
  typedef struct packed {
    logic bi;
    logic fe;
    logic pe;
    logic [7:0] data;
  } afsp_rx_entry_s;

  typedef struct packed {
    logic [3:0] ier;
    logic [7:0] lcr;
    logic [4:0] mcr;
    logic [7:0] scr;
    logic [7:0] dll;
    logic [7:0] dlm;
    logic fifo_en;
    logic [1:0] rx_trig;
    logic dma_mode;
    logic [15:0][7:0] tx_mem;
    logic [3:0] tx_wp;
    logic [3:0] tx_rp;
    logic [4:0] tx_cnt;
    logic [15:0][10:0] rx_mem;
    logic [3:0] rx_wp;
    logic [3:0] rx_rp;
    logic [4:0] rx_cnt;
    logic top_seen;
    logic [3:0] lsr_err;
    logic err_in_fifo;
    logic tx_hold_vacant_int;
    logic [3:0] msr_prev;
    logic [3:0] msr_delta;
    logic [15:0] baud_cnt;
    logic tick;
    afsp_tx_e tx_state;
    logic [7:0] tx_shift;
    logic [2:0] tx_bitcnt;
    logic [5:0] tx_ticks;
    logic tx_par;
    logic tx_line;
    afsp_rx_e rx_state;
    logic [7:0] rx_shift;
    logic [2:0] rx_bitcnt;
    logic [5:0] rx_ticks;
    logic rx_par;
    logic rx_zero;
    logic rx_brk_wait;
    logic [9:0] to_cnt;
    logic to_flag;
    logic [7:0] rdata;
    logic serial_tx_pin;
    afsp_modem_out_s mout;
    logic irq;
    logic rx_req_n;
    logic tx_req_n;
  } afsp_state_s;
endpackage : afsp_pkg

//--- hdl/afsp_uart.sv
// single serial channel with 16-byte queues and byte-wide register port
`timescale 1ns/100ps
module afsp_uart (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic serial_rx_pin_i,
  output logic serial_tx_pin_o,
  input wire afsp_pkg::afsp_modem_in_s modem_n_i,
  output afsp_pkg::afsp_modem_out_s modem_n_o,
  output logic irq_o,
  output logic rx_transfer_req_n_o,
  output logic tx_transfer_req_n_o
);

  function automatic logic [3:0] afsp_data_bits(input logic [7:0] lcr);
    afsp_data_bits = 4'h5 + {2'b00, lcr[1:0]};
  endfunction : afsp_data_bits

  // parity bit to send or expect for a character
  function automatic logic afsp_parity(input logic [7:0] data, input logic [7:0] lcr);
    logic [7:0] mask;
    mask = 8'hff >> (4'h8 - afsp_data_bits(lcr));
    if (lcr[afsp_pkg::LCR_STICK]) begin
      afsp_parity = ~lcr[afsp_pkg::LCR_EVEN];
    end else begin
      afsp_parity = (^(data & mask)) ^ ~lcr[afsp_pkg::LCR_EVEN];
    end
  endfunction : afsp_parity

  function automatic logic [4:0] afsp_trig(input logic [1:0] sel);
    case (sel)
      2'h0: afsp_trig = afsp_pkg::TRIG_1;
      2'h1: afsp_trig = afsp_pkg::TRIG_4;
      2'h2: afsp_trig = afsp_pkg::TRIG_8;
      default: afsp_trig = afsp_pkg::TRIG_14;
    endcase
  endfunction : afsp_trig

  afsp_pkg::afsp_state_s s;
  afsp_pkg::afsp_state_s n;

  logic loop;
  logic divisor_window_sel;
  logic [4:0] cap;
  logic rx_line;
  logic [3:0] msr_now;
  logic [15:0] div_m1;
  logic [3:0] nbits;
  logic [5:0] stop_ticks;
  logic [3:0] frame_bits;
  logic [9:0] to_lim;
  logic trig_hit;
  logic rd_rbr;
  logic wr_thr;
  logic rd_iir;
  logic rd_lsr;
  logic rd_msr;
  logic ls_pend;
  logic rda_pend;
  logic to_pend;
  logic tx_hold_vacant_pend;
  logic ms_pend;
  logic [3:0] iir_code;
  logic tx_all_idle;
  logic tx_hold_vacant;
  logic rx_char_avail;
  afsp_pkg::afsp_rx_entry_s rx_top;

  assign loop = s.mcr[afsp_pkg::MCR_LOOP];
  assign divisor_window_sel = s.lcr[afsp_pkg::LCR_DIVISOR_WINDOW_SEL];
  assign cap = s.fifo_en ? afsp_pkg::FIFO_DEPTH : 5'h01;
  assign rx_line = loop ? s.tx_line : serial_rx_pin_i;
  // asserted levels: carrier, ring, set ready, clear to send
  assign msr_now = loop ? {s.mcr[afsp_pkg::MCR_USER_OUT_B], s.mcr[afsp_pkg::MCR_USER_OUT_A],
                           s.mcr[afsp_pkg::MCR_DTR], s.mcr[afsp_pkg::MCR_RTS]}
                        : ~{modem_n_i.dcd_n, modem_n_i.ri_n,
                            modem_n_i.dsr_n, modem_n_i.cts_n};
  assign div_m1 = ({s.dlm, s.dll} == 16'h0000) ? 16'h0000 : {s.dlm, s.dll} - 16'h0001;
  assign nbits = afsp_data_bits(s.lcr);
  assign stop_ticks = !s.lcr[afsp_pkg::LCR_STB] ? afsp_pkg::TICKS_STOP_1 :
                      (s.lcr[1:0] == 2'h0) ? afsp_pkg::TICKS_STOP_15 :
                      afsp_pkg::TICKS_STOP_2;
  assign frame_bits = 4'h1 + nbits + {3'h0, s.lcr[afsp_pkg::LCR_PEN]}
                      + (s.lcr[afsp_pkg::LCR_STB] ? 4'h2 : 4'h1);
  assign to_lim = 10'(frame_bits * afsp_pkg::TIMEOUT_TICKS_PER_BIT);
  assign trig_hit = s.rx_cnt >= afsp_trig(s.rx_trig);
  assign rd_rbr = rd_i && addr_i == afsp_pkg::OFS_DATA && !divisor_window_sel;
  assign wr_thr = wr_i && addr_i == afsp_pkg::OFS_DATA && !divisor_window_sel;
  assign rd_iir = rd_i && addr_i == afsp_pkg::OFS_IIR_FCR;
  assign rd_lsr = rd_i && addr_i == afsp_pkg::OFS_LSR;
  assign rd_msr = rd_i && addr_i == afsp_pkg::OFS_MSR;
  assign ls_pend = s.ier[2] && (|s.lsr_err);
  assign rda_pend = s.ier[0] && (s.fifo_en ? trig_hit : s.rx_cnt != 5'h00);
  assign to_pend = s.ier[0] && s.fifo_en && s.to_flag;
  assign tx_hold_vacant_pend = s.ier[1] && s.tx_hold_vacant_int;
  assign ms_pend = s.ier[3] && (|s.msr_delta);
  assign iir_code = ls_pend ? afsp_pkg::IIR_LS :
                    rda_pend ? afsp_pkg::IIR_RDA :
                    to_pend ? afsp_pkg::IIR_TO :
                    tx_hold_vacant_pend ? afsp_pkg::IIR_TX_HOLD_VACANT :
                    ms_pend ? afsp_pkg::IIR_MS : afsp_pkg::IIR_NONE;
  assign tx_hold_vacant = s.tx_cnt == 5'h00;
  assign tx_all_idle = tx_hold_vacant && s.tx_state == afsp_pkg::AFSP_TX_IDLE;
  assign rx_char_avail = s.rx_cnt != 5'h00;
  assign rx_top = afsp_pkg::afsp_rx_entry_s'(s.rx_mem[s.rx_rp]);

  always_comb begin
    logic pop_tx;
    logic push_tx;
    logic pop_rx;
    logic push_rx;
    logic ovw_rx;
    afsp_pkg::afsp_rx_entry_s rx_val;
    logic brk;
    pop_tx = 1'b0;
    push_tx = 1'b0;
    pop_rx = 1'b0;
    push_rx = 1'b0;
    ovw_rx = 1'b0;
    rx_val = '0;
    brk = 1'b0;
    n = s;

    // sixteen-times sampling tick from the divisor
    n.tick = 1'b0;
    if (s.baud_cnt >= div_m1) begin
      n.baud_cnt = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.baud_cnt = s.baud_cnt + 16'h0001;
    end

    // transmitter
    case (s.tx_state)
      afsp_pkg::AFSP_TX_IDLE: begin
        if (s.tx_cnt != 5'h00) begin
          n.tx_shift = s.tx_mem[s.tx_rp];
          n.tx_par = afsp_parity(s.tx_mem[s.tx_rp], s.lcr);
          pop_tx = 1'b1;
          n.tx_line = 1'b0;
          n.tx_ticks = afsp_pkg::TICKS_BIT - 6'h01;
          n.tx_state = afsp_pkg::AFSP_TX_START;
        end
      end
      afsp_pkg::AFSP_TX_START: begin
        if (s.tick) begin
          if (s.tx_ticks == 6'h00) begin
            n.tx_line = s.tx_shift[0];
            n.tx_bitcnt = 3'h0;
            n.tx_ticks = afsp_pkg::TICKS_BIT - 6'h01;
            n.tx_state = afsp_pkg::AFSP_TX_DATA;
          end else begin
            n.tx_ticks = s.tx_ticks - 6'h01;
          end
        end
      end
      afsp_pkg::AFSP_TX_DATA: begin
        if (s.tick) begin
          if (s.tx_ticks == 6'h00) begin
            n.tx_ticks = afsp_pkg::TICKS_BIT - 6'h01;
            if ({1'b0, s.tx_bitcnt} == nbits - 4'h1) begin
              if (s.lcr[afsp_pkg::LCR_PEN]) begin
                n.tx_line = s.tx_par;
                n.tx_state = afsp_pkg::AFSP_TX_PAR;
              end else begin
                n.tx_line = 1'b1;
                n.tx_ticks = stop_ticks - 6'h01;
                n.tx_state = afsp_pkg::AFSP_TX_STOP;
              end
            end else begin
              n.tx_bitcnt = s.tx_bitcnt + 3'h1;
              n.tx_shift = s.tx_shift >> 1;
              n.tx_line = s.tx_shift[1];
            end
          end else begin
            n.tx_ticks = s.tx_ticks - 6'h01;
          end
        end
      end
      afsp_pkg::AFSP_TX_PAR: begin
        if (s.tick) begin
          if (s.tx_ticks == 6'h00) begin
            n.tx_line = 1'b1;
            n.tx_ticks = stop_ticks - 6'h01;
            n.tx_state = afsp_pkg::AFSP_TX_STOP;
          end else begin
            n.tx_ticks = s.tx_ticks - 6'h01;
          end
        end
      end
      default: begin
        if (s.tick) begin
          if (s.tx_ticks == 6'h00) begin
            n.tx_state = afsp_pkg::AFSP_TX_IDLE;
          end else begin
            n.tx_ticks = s.tx_ticks - 6'h01;
          end
        end
      end
    endcase

    // receiver, sampling near mid-bit
    case (s.rx_state)
      afsp_pkg::AFSP_RX_IDLE: begin
        if (s.rx_brk_wait) begin
          if (rx_line) begin
            n.rx_brk_wait = 1'b0;
          end
        end else if (!rx_line) begin
          n.rx_ticks = afsp_pkg::TICKS_HALF - 6'h01;
          n.rx_state = afsp_pkg::AFSP_RX_START;
        end
      end
      afsp_pkg::AFSP_RX_START: begin
        if (s.tick) begin
          if (s.rx_ticks == 6'h00) begin
            if (!rx_line) begin
              n.rx_shift = 8'h00;
              n.rx_bitcnt = 3'h0;
              n.rx_zero = 1'b1;
              n.rx_ticks = afsp_pkg::TICKS_BIT - 6'h01;
              n.rx_state = afsp_pkg::AFSP_RX_DATA;
            end else begin
              n.rx_state = afsp_pkg::AFSP_RX_IDLE;
            end
          end else begin
            n.rx_ticks = s.rx_ticks - 6'h01;
          end
        end
      end
      afsp_pkg::AFSP_RX_DATA: begin
        if (s.tick) begin
          if (s.rx_ticks == 6'h00) begin
            n.rx_shift[s.rx_bitcnt] = rx_line;
            n.rx_zero = s.rx_zero & ~rx_line;
            n.rx_ticks = afsp_pkg::TICKS_BIT - 6'h01;
            if ({1'b0, s.rx_bitcnt} == nbits - 4'h1) begin
              n.rx_state = s.lcr[afsp_pkg::LCR_PEN] ? afsp_pkg::AFSP_RX_PAR
                                                      : afsp_pkg::AFSP_RX_STOP;
            end else begin
              n.rx_bitcnt = s.rx_bitcnt + 3'h1;
            end
          end else begin
            n.rx_ticks = s.rx_ticks - 6'h01;
          end
        end
      end
      afsp_pkg::AFSP_RX_PAR: begin
        if (s.tick) begin
          if (s.rx_ticks == 6'h00) begin
            n.rx_par = rx_line;
            n.rx_zero = s.rx_zero & ~rx_line;
            n.rx_ticks = afsp_pkg::TICKS_BIT - 6'h01;
            n.rx_state = afsp_pkg::AFSP_RX_STOP;
          end else begin
            n.rx_ticks = s.rx_ticks - 6'h01;
          end
        end
      end
      default: begin
        if (s.tick) begin
          if (s.rx_ticks == 6'h00) begin
            brk = s.rx_zero && !rx_line;
            push_rx = 1'b1;
            if (brk) begin
              rx_val.bi = 1'b1;
              n.rx_brk_wait = 1'b1;
            end else begin
              rx_val.data = s.rx_shift;
              rx_val.fe = !rx_line;
              rx_val.pe = s.lcr[afsp_pkg::LCR_PEN]
                          && (s.rx_par != afsp_parity(s.rx_shift, s.lcr));
            end
            n.rx_state = afsp_pkg::AFSP_RX_IDLE;
          end else begin
            n.rx_ticks = s.rx_ticks - 6'h01;
          end
        end
      end
    endcase

    // host register writes
    if (wr_i) begin
      if (addr_i == afsp_pkg::OFS_DATA && divisor_window_sel) begin
        n.dll = wdata_i;
      end else if (addr_i == afsp_pkg::OFS_DATA) begin
        push_tx = s.tx_cnt < cap;
        n.tx_hold_vacant_int = 1'b0;
      end else if (addr_i == afsp_pkg::OFS_IER && divisor_window_sel) begin
        n.dlm = wdata_i;
      end else if (addr_i == afsp_pkg::OFS_IER) begin
        n.ier = wdata_i[3:0];
        if (wdata_i[1] && !s.ier[1] && tx_hold_vacant) begin
          n.tx_hold_vacant_int = 1'b1;
        end
      end else if (addr_i == afsp_pkg::OFS_LCR) begin
        n.lcr = wdata_i;
      end else if (addr_i == afsp_pkg::OFS_MCR) begin
        n.mcr = wdata_i[4:0];
      end else if (addr_i == afsp_pkg::OFS_SCR) begin
        n.scr = wdata_i;
      end
    end

    // host register reads and their side effects
    if (rd_i) begin
      if (addr_i == afsp_pkg::OFS_DATA && divisor_window_sel) begin
        n.rdata = s.dll;
      end else if (addr_i == afsp_pkg::OFS_DATA) begin
        n.rdata = rx_top.data;
        pop_rx = rx_char_avail;
      end else if (addr_i == afsp_pkg::OFS_IER && divisor_window_sel) begin
        n.rdata = s.dlm;
      end else if (addr_i == afsp_pkg::OFS_IER) begin
        n.rdata = {4'h0, s.ier};
      end else if (addr_i == afsp_pkg::OFS_IIR_FCR) begin
        n.rdata = {s.fifo_en, s.fifo_en, 2'b00, iir_code};
      end else if (addr_i == afsp_pkg::OFS_LCR) begin
        n.rdata = s.lcr;
      end else if (addr_i == afsp_pkg::OFS_MCR) begin
        n.rdata = {3'h0, s.mcr};
      end else if (addr_i == afsp_pkg::OFS_LSR) begin
        n.rdata = {s.err_in_fifo && s.fifo_en, tx_all_idle, tx_hold_vacant,
                   s.lsr_err, rx_char_avail};
      end else if (addr_i == afsp_pkg::OFS_MSR) begin
        n.rdata = {msr_now, s.msr_delta};
      end else begin
        n.rdata = s.scr;
      end
    end
    if (rd_iir && iir_code == afsp_pkg::IIR_TX_HOLD_VACANT) begin
      n.tx_hold_vacant_int = 1'b0;
    end
    if (rd_lsr) begin
      n.lsr_err = 4'h0;
      n.err_in_fifo = 1'b0;
    end
    if (rd_msr) begin
      n.msr_delta = 4'h0;
    end

    // transmit queue bookkeeping
    if (push_tx) begin
      n.tx_mem[s.tx_wp] = wdata_i;
      n.tx_wp = s.tx_wp + 4'h1;
    end
    if (pop_tx) begin
      n.tx_rp = s.tx_rp + 4'h1;
    end
    n.tx_cnt = s.tx_cnt + {4'h0, push_tx} - {4'h0, pop_tx};

    // receive queue bookkeeping and overrun
    if (push_rx) begin
      if (s.rx_cnt < cap || pop_rx) begin
        n.rx_mem[s.rx_wp] = rx_val;
        n.rx_wp = s.rx_wp + 4'h1;
        if (s.fifo_en && (rx_val.bi || rx_val.fe || rx_val.pe)) begin
          n.err_in_fifo = 1'b1;
        end
      end else begin
        n.lsr_err[0] = 1'b1;
        if (!s.fifo_en) begin
          n.rx_mem[s.rx_rp] = rx_val;
          ovw_rx = 1'b1;
        end
        push_rx = 1'b0;
      end
    end
    if (pop_rx) begin
      n.rx_rp = s.rx_rp + 4'h1;
    end
    n.rx_cnt = s.rx_cnt + {4'h0, push_rx} - {4'h0, pop_rx};
    if (pop_rx || ovw_rx) begin
      n.top_seen = 1'b0;
    end else if (rx_char_avail && !s.top_seen) begin
      n.top_seen = 1'b1;
      // merge into the next value so a status read in this cycle keeps its clear
      n.lsr_err[3:1] = n.lsr_err[3:1] | {rx_top.bi, rx_top.fe, rx_top.pe};
    end
    if (ovw_rx) begin
      n.lsr_err[3:1] = n.lsr_err[3:1] | {rx_val.bi, rx_val.fe, rx_val.pe};
    end

    // character timeout
    if (push_rx || pop_rx || !rx_char_avail) begin
      n.to_cnt = 10'h000;
      n.to_flag = 1'b0;
    end else if (s.tick && !s.to_flag) begin
      if (s.to_cnt >= to_lim - 10'h001) begin
        n.to_flag = 1'b1;
      end else begin
        n.to_cnt = s.to_cnt + 10'h001;
      end
    end

    // queue setup writes
    if (wr_i && addr_i == afsp_pkg::OFS_IIR_FCR) begin
      if (wdata_i[afsp_pkg::FCR_EN]) begin
        n.fifo_en = 1'b1;
        n.rx_trig = wdata_i[7:6];
        n.dma_mode = wdata_i[afsp_pkg::FCR_DMA];
      end else begin
        n.fifo_en = 1'b0;
      end
      if (wdata_i[afsp_pkg::FCR_RXF] || !wdata_i[afsp_pkg::FCR_EN] || !s.fifo_en) begin
        n.rx_wp = 4'h0;
        n.rx_rp = 4'h0;
        n.rx_cnt = 5'h00;
        n.top_seen = 1'b0;
        n.err_in_fifo = 1'b0;
        n.to_cnt = 10'h000;
        n.to_flag = 1'b0;
      end
      if (wdata_i[afsp_pkg::FCR_TXF] || !wdata_i[afsp_pkg::FCR_EN] || !s.fifo_en) begin
        n.tx_wp = 4'h0;
        n.tx_rp = 4'h0;
        n.tx_cnt = 5'h00;
      end
    end

    // late sets win over clears done above; an empty receive queue clears the fault flag
    if (s.tx_cnt != 5'h00 && n.tx_cnt == 5'h00) begin
      n.tx_hold_vacant_int = 1'b1;
    end
    if (n.rx_cnt == 5'h00) begin
      n.err_in_fifo = 1'b0;
    end
    n.msr_prev = msr_now;
    n.msr_delta = n.msr_delta | {msr_now[3] ^ s.msr_prev[3], s.msr_prev[2] & ~msr_now[2],
                                 msr_now[1] ^ s.msr_prev[1],
                                 msr_now[0] ^ s.msr_prev[0]};

    // registered pins
    n.serial_tx_pin = loop ? 1'b1 : (n.lcr[afsp_pkg::LCR_BRK] ? 1'b0 : n.tx_line);
    n.mout = n.mcr[afsp_pkg::MCR_LOOP] ? 4'hf : ~n.mcr[3:0];
    n.irq = ls_pend || rda_pend || to_pend || tx_hold_vacant_pend || ms_pend;
    if (s.dma_mode && s.fifo_en) begin
      n.rx_req_n = !(trig_hit || s.to_flag);
      n.tx_req_n = s.tx_cnt == afsp_pkg::FIFO_DEPTH;
    end else begin
      n.rx_req_n = !rx_char_avail;
      n.tx_req_n = !tx_hold_vacant;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
      s.dll <= afsp_pkg::DIV_RST[7:0];
      s.dlm <= afsp_pkg::DIV_RST[15:8];
      s.tx_state <= afsp_pkg::AFSP_TX_IDLE;
      s.rx_state <= afsp_pkg::AFSP_RX_IDLE;
      s.tx_line <= 1'b1;
      s.serial_tx_pin <= 1'b1;
      s.mout <= 4'hf;
      s.rx_req_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign rdata_o = s.rdata;
  assign serial_tx_pin_o = s.serial_tx_pin;
  assign modem_n_o = s.mout;
  assign irq_o = s.irq;
  assign rx_transfer_req_n_o = s.rx_req_n;
  assign tx_transfer_req_n_o = s.tx_req_n;

endmodule : afsp_uart

//--- sim/afsp_uart_sva.sv
// port assertions for the serial channel
`timescale 1ns/100ps
module afsp_uart_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic serial_tx_pin_o,
  input wire afsp_pkg::afsp_modem_in_s modem_n_i,
  input wire afsp_pkg::afsp_modem_out_s modem_n_o
);
  logic [7:0] lcr_q, mcr_q, scr_q, dll_q;
  logic fen_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // shadow copies of host writes
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lcr_q <= 8'h00;
      mcr_q <= 8'h00;
      scr_q <= 8'h00;
      dll_q <= 8'h01;
      fen_q <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == 3'h3) lcr_q <= wdata_i;
      if (addr_i == 3'h4) mcr_q <= wdata_i;
      if (addr_i == 3'h7) scr_q <= wdata_i;
      if (addr_i == 3'h0 && lcr_q[7]) dll_q <= wdata_i;
      if (addr_i == 3'h2) fen_q <= wdata_i[0];
    end
  end
  a_break_space: assert property (lcr_q[6] && $past(lcr_q[6]) && !mcr_q[4] |-> !serial_tx_pin_o)
    else $error("break not at space");
  a_mout_inverse: assert property ($stable(mcr_q) && !mcr_q[4] |-> modem_n_o == ~mcr_q[3:0])
    else $error("modem output level wrong");
  a_loop_idle: assert property (mcr_q[4] && $past(mcr_q[4]) |-> modem_n_o == 4'hf)
    else $error("loop outputs active");
  a_scratch_back: assert property (rd_i && addr_i == 3'h7 |=> rdata_o == $past(scr_q))
    else $error("scratch readback wrong");
  a_msr_levels: assert property (rd_i && addr_i == 3'h6 && !mcr_q[4] && $past(modem_n_i, 2) == modem_n_i
    |=> rdata_o[7:4] == ~$past(modem_n_i))
    else $error("modem levels wrong");
  a_fault_char: assert property (rd_i && addr_i == 3'h5 && !fen_q |=> !rdata_o[7])
    else $error("fault bit in char mode");
  a_dll_window: assert property (rd_i && addr_i == 3'h0 && lcr_q[7] |=> rdata_o == $past(dll_q))
    else $error("divisor window wrong");
  a_tx_all_idle_cleared: assert property (wr_i && addr_i == 3'h0 && !lcr_q[7] ##2 rd_i && addr_i == 3'h5
    |=> !rdata_o[6])
    else $error("idle flag after write");
  c_break: cover property (lcr_q[6] && !serial_tx_pin_o);
  c_loop: cover property (mcr_q[4] && rd_i);
  c_fifo_read: cover property (fen_q && rd_i && addr_i == 3'h0);
endmodule : afsp_uart_sva
bind afsp_uart afsp_uart_sva u_sva (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
  .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .serial_tx_pin_o(serial_tx_pin_o), .modem_n_i(modem_n_i), .modem_n_o(modem_n_o));

//--- sim/afsp_line_model.sv
// far-side terminal: serial frames and modem levels
`timescale 1ns/100ps
module afsp_line_model (
  input wire logic clk_i,
  output logic line_o,
  output afsp_pkg::afsp_modem_in_s modem_n_o
);
  initial begin
    line_o = 1'b1;
    modem_n_o = 4'b0110;
  end
  // lsb first, 16 clocks a bit, then a bit of mark
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_o <= f[i];
      repeat (16) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (16) @(posedge clk_i);
  endtask : send
endmodule : afsp_line_model

//--- sim/tb_fifo_async_serial_port.sv
// self-checking bench for the serial channel
`timescale 1ns/100ps
module tb_fifo_async_serial_port;
  logic clk_i = 1'b0, reset_i = 1'b1, rd_i = 1'b0, wr_i = 1'b0, rx_pin, tx_pin, irq, rxr_n, txr_n;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  afsp_pkg::afsp_modem_in_s min_n;
  afsp_pkg::afsp_modem_out_s mout_n;
  int fails = 0, checked = 0;
  int trig[4] = '{1, 4, 8, 14};
  afsp_uart DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .serial_rx_pin_i(rx_pin), .serial_tx_pin_o(tx_pin),
    .modem_n_i(min_n), .modem_n_o(mout_n), .irq_o(irq), .rx_transfer_req_n_o(rxr_n),
    .tx_transfer_req_n_o(txr_n));
  afsp_line_model FAR (.clk_i(clk_i), .line_o(rx_pin), .modem_n_o(min_n));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o & m, e);
  endtask : rd
  task automatic close_out;
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  initial begin
    #300us;
    fails++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(3'h5, 8'hff, 8'h60);
    chk({6'h00, rxr_n, txr_n}, 8'h02);
    rd(3'h2, 8'h0f, 8'h01);
    wr(3'h7, 8'h5a);
    rd(3'h7, 8'hff, 8'h5a);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rd(3'h0, 8'hff, 8'h01);
    wr(3'h3, 8'h1b);
    wr(3'h4, 8'h0b);
    wt(3);
    chk({4'h0, mout_n}, 8'h04);
    rd(3'h6, 8'hf0, 8'h90);
    FAR.modem_n_o.cts_n <= 1'b1;
    wt(4);
    rd(3'h6, 8'hff, 8'h81);
    rd(3'h6, 8'hff, 8'h80);
    wr(3'h3, 8'h5b);
    wt(3);
    chk({7'h00, tx_pin}, 8'h00);
    wr(3'h3, 8'h1b);
    FAR.send(12'h478, 11);
    rd(3'h5, 8'hff, 8'h61);
    rd(3'h0, 8'hff, 8'h3c);
    FAR.send(12'h678, 11);
    rd(3'h5, 8'hff, 8'h65);
    rd(3'h0, 8'hff, 8'h3c);
    FAR.send(12'h078, 11);
    rd(3'h5, 8'hff, 8'h69);
    rd(3'h5, 8'hff, 8'h61);
    wr(3'h4, 8'h1f);
    wt(3);
    chk({4'h0, mout_n}, 8'h0f);
    rd(3'h6, 8'hf0, 8'hf0);
    wr(3'h0, 8'ha5);
    rd(3'h5, 8'h40, 8'h00);
    wt(250);
    rd(3'h0, 8'hff, 8'ha5);
    wr(3'h4, 8'h08);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h01);
    for (int t = 0; t < 4; t++) begin
      wr(3'h2, {t[1:0], 6'h0f});
      for (int k = 1; k < trig[t]; k++) FAR.send(12'h2aa, 10);
      chk({6'h00, irq, rxr_n}, 8'h01);
      FAR.send(12'h2aa, 10);
      chk({6'h00, irq, rxr_n}, 8'h02);
      rd(3'h2, 8'h8f, 8'h84);
      rd(3'h0, 8'hff, 8'h55);
      wt(2);
      chk({6'h00, irq, rxr_n}, 8'h01);
    end
    wr(3'h2, 8'h03);
    rd(3'h5, 8'hf1, 8'h60);
    // all-space frame in queue mode: one zero character flagged as break
    FAR.send(12'h000, 10);
    rd(3'h5, 8'hff, 8'hf1);
    rd(3'h0, 8'hff, 8'h00);
    rd(3'h5, 8'hff, 8'h60);
    // one byte below a trigger of four, then four character times of silence
    wr(3'h2, 8'h41);
    FAR.send(12'h2aa, 10);
    wt(700);
    rd(3'h2, 8'h8f, 8'h8c);
    rd(3'h0, 8'hff, 8'h55);
    rd(3'h2, 8'h8f, 8'h81);
    // flush queued bytes while the shifter is busy with the first one
    repeat (3) wr(3'h0, 8'h3c);
    wr(3'h2, 8'h05);
    rd(3'h5, 8'h60, 8'h20);
    close_out();
  end
endmodule : tb_fifo_async_serial_port
